// *** core/cpo_defs.svh ***
`ifndef CPO_DEFS_SVH
`define CPO_DEFS_SVH

// Register word indices; byte address is four times the index
`define CPO_IDX_SPACING   10'h000
`define CPO_IDX_BASE_LO   10'h001
`define CPO_IDX_BASE_HI   10'h002
`define CPO_IDX_CHAN_LO   10'h003
`define CPO_IDX_COMMIT    10'h004
`define CPO_IDX_SYNTH     10'h005
`define CPO_IDX_CENTER    10'h006
`define CPO_IDX_OSC       10'h009

// Field positions
`define CPO_SCHEME_HI     7
`define CPO_SCHEME_LO     6
`define CPO_CN_MSB_BIT    0
`define CPO_BW_HI         5
`define CPO_BW_LO         4
`define CPO_LOCK_BIT      1
`define CPO_FAST_BIT      4
`define CPO_TRIM_HI       3

// Reset values
`define CPO_RST_SPACING   8'h08
`define CPO_RST_BASE_LO   8'hf8
`define CPO_RST_BASE_HI   8'h8c
`define CPO_RST_CHAN_LO   8'h00
`define CPO_RST_OSC_FAST  1'b1
`define CPO_RST_TRIM      4'h0

// 1.5 GHz expressed in 25 kHz steps
`define CPO_OFFSET_2G4    24'h00ea60

`endif

// *** core/cpo_pkg.sv ***
package cpo_pkg;

    typedef enum logic [1:0] {
        scheme_ieee,
        scheme_fine_lo,
        scheme_fine_mid,
        scheme_fine_hi
    } cpo_scheme_t;

    typedef enum logic [1:0] {
        bw_default,
        bw_narrow,
        bw_wide,
        bw_unused
    } cpo_bw_t;

endpackage

// *** core/cpo_regs.sv ***
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "cpo_defs.svh"
// What this block does
// - Commit register write loads staged channel values
// - Scheme zero: base plus number times spacing, plus 1.5 GHz in 2.4 GHz radio
// - Scheme one: fine word, low sub-GHz range
// - Scheme two: fine word, high sub-GHz range
// - Scheme three: fine word, 2.4 GHz range
// - Loop bandwidth field picks synthesizer bandwidth
// - Loop bandwidth only acts in sub-GHz radio
// - Lock flag reads synthesizer lock, resets zero
// - Calibrate on radio-off to prepare and channel change
// - Center register reports calibrated six-bit value
// - Oscillator fast start-up bit, resets to one
// - Four-bit load capacitor trim field
// - Lock loss and regain raise event pulses
module cpo_regs #(
    parameter bit IS_SUBGHZ = 1'b1              // 1: sub-GHz radio, 0: 2.4 GHz radio
) (
    input  wire logic        pclk,              // Register clock
    input  wire logic        presetn,           // Async reset, active low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB enable
    input  wire logic        pwrite,            // APB direction
    input  wire logic [11:0] paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    input  wire logic [3:0]  pstrb,             // APB byte strobes
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    input  wire logic        lock_pin,          // Synthesizer lock, async
    input  wire logic        transmit_prepare_state_pin,        // Radio in transmit prepare, async
    input  wire logic        cal_done_pin,      // Calibration result valid, async
    input  wire logic [5:0]  cal_value_pin,     // Calibration result, async
    output logic      [23:0] chan_word,         // Active channel word
    output logic      [1:0]  scheme_select,     // Active channel scheme
    output logic      [1:0]  loop_bw_adjust,    // Bandwidth to synthesizer
    output logic             cal_start,         // Calibration start pulse
    output logic             fast_startup_enable, // Oscillator fast start
    output logic      [3:0]  trim,              // Load capacitor trim
    output logic             transceiver_error_irq, // Lock lost pulse
    output logic             transceiver_ready_irq  // Lock regained pulse
);

    // ****************************************
    // Bus decode
    // ****************************************
    logic [9:0] idx;
    logic       setup;
    logic       wr_en;
    logic       mapped;

    assign idx   = paddr[11:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

    always_comb
    begin
        case (idx)
            `CPO_IDX_SPACING, `CPO_IDX_BASE_LO, `CPO_IDX_BASE_HI,
            `CPO_IDX_CHAN_LO, `CPO_IDX_COMMIT, `CPO_IDX_SYNTH,
            `CPO_IDX_CENTER, `CPO_IDX_OSC: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    logic [2:0] prev_q;
    logic       lock_s;
    logic       transmit_prepare_state_s;
    logic       done_s;
    logic [5:0] value_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
            prev_q  <= 3'h0;
        end
        else
        begin
            sync1_q <= {cal_value_pin, cal_done_pin, transmit_prepare_state_pin, lock_pin};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q[2:0];
        end
    end

    assign lock_s   = sync2_q[0];
    assign transmit_prepare_state_s = sync2_q[1];
    assign done_s   = sync2_q[2];
    assign value_s  = sync2_q[8:3];

    // ****************************************
    // Staged channel registers
    // ****************************************
    logic [7:0] spacing_q;
    logic [7:0] base_lo_q;
    logic [7:0] base_hi_q;
    logic [7:0] chan_lo_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spacing_q <= `CPO_RST_SPACING;
            base_lo_q <= `CPO_RST_BASE_LO;
            base_hi_q <= `CPO_RST_BASE_HI;
            chan_lo_q <= `CPO_RST_CHAN_LO;
        end
        else if (wr_en)
        begin
            case (idx)
                `CPO_IDX_SPACING: spacing_q <= pwdata[7:0];
                `CPO_IDX_BASE_LO: base_lo_q <= pwdata[7:0];
                `CPO_IDX_BASE_HI: base_hi_q <= pwdata[7:0];
                `CPO_IDX_CHAN_LO: chan_lo_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // Channel commit and frequency word
    // ****************************************
    logic        commit;
    logic [1:0]  scheme_d;
    logic [8:0]  cn_d;
    logic [16:0] prod;
    logic [23:0] ieee_word;
    logic [23:0] fine_word;
    logic        scheme_ok;
    logic        cn_msb_q;

    assign commit   = wr_en && (idx == `CPO_IDX_COMMIT);
    assign scheme_d = pwdata[`CPO_SCHEME_HI:`CPO_SCHEME_LO];
    assign cn_d     = {pwdata[`CPO_CN_MSB_BIT], chan_lo_q};
    assign prod     = cn_d * spacing_q;
    // Offset is zero for sub-GHz, 1.5 GHz for 2.4 GHz
    assign ieee_word = {8'h00, base_hi_q, base_lo_q} + {7'h00, prod}
                     + (IS_SUBGHZ ? 24'h000000 : `CPO_OFFSET_2G4);
    assign fine_word = {base_hi_q, base_lo_q, chan_lo_q};

    // Fine schemes of the other band leave the channel word unchanged and start no calibration in this radio
    always_comb
    begin
        case (cpo_pkg::cpo_scheme_t'(scheme_d))
            cpo_pkg::scheme_ieee:     scheme_ok = 1'b1;
            cpo_pkg::scheme_fine_lo:  scheme_ok = IS_SUBGHZ;
            cpo_pkg::scheme_fine_mid: scheme_ok = IS_SUBGHZ;
            default:                  scheme_ok = !IS_SUBGHZ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scheme_select <= 2'h0;
            cn_msb_q      <= 1'b0;
            chan_word     <= `CPO_RST_BASE_HI * 24'h000100 + 24'(`CPO_RST_BASE_LO)
                           + (IS_SUBGHZ ? 24'h000000 : `CPO_OFFSET_2G4);
        end
        else if (commit)
        begin
            scheme_select <= scheme_d;
            cn_msb_q      <= pwdata[`CPO_CN_MSB_BIT];
            if (scheme_ok)
            begin
                if (scheme_d == 2'h0)
                    chan_word <= ieee_word;
                else
                    chan_word <= fine_word;
            end
        end
    end

    // ****************************************
    // Synthesizer, calibration, lock events
    // ****************************************
    logic [1:0] bw_q;
    logic [5:0] center_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bw_q           <= 2'h0;
            loop_bw_adjust <= 2'h0;
        end
        else
        begin
            if (wr_en && idx == `CPO_IDX_SYNTH)
                bw_q <= pwdata[`CPO_BW_HI:`CPO_BW_LO];
            loop_bw_adjust <= IS_SUBGHZ ? bw_q : 2'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_start <= 1'b0;
            center_q  <= 6'h00;
        end
        else
        begin
            cal_start <= (transmit_prepare_state_s && !prev_q[1]) || (commit && scheme_ok);
            if (done_s && !prev_q[2])
                center_q <= value_s;
        end
    end

    // Lock flag is read straight from the synchronised pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transceiver_error_irq <= 1'b0;
            transceiver_ready_irq <= 1'b0;
        end
        else
        begin
            transceiver_error_irq <= !lock_s && prev_q[0];
            transceiver_ready_irq <= lock_s && !prev_q[0];
        end
    end

    // ****************************************
    // Oscillator control
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_startup_enable <= `CPO_RST_OSC_FAST;
            trim                <= `CPO_RST_TRIM;
        end
        else if (wr_en && idx == `CPO_IDX_OSC)
        begin
            fast_startup_enable <= pwdata[`CPO_FAST_BIT];
            trim                <= pwdata[`CPO_TRIM_HI:0];
        end
    end

    // ****************************************
    // Read path and bus answer
    // ****************************************
    logic [7:0] rd_byte;

    always_comb
    begin
        case (idx)
            `CPO_IDX_SPACING: rd_byte = spacing_q;
            `CPO_IDX_BASE_LO: rd_byte = base_lo_q;
            `CPO_IDX_BASE_HI: rd_byte = base_hi_q;
            `CPO_IDX_CHAN_LO: rd_byte = chan_lo_q;
            `CPO_IDX_COMMIT:  rd_byte = {scheme_select, 5'h00, cn_msb_q};
            `CPO_IDX_SYNTH:   rd_byte = {2'h0, bw_q, 2'h0, lock_s, 1'b0};
            `CPO_IDX_CENTER:  rd_byte = {2'h0, center_q};
            `CPO_IDX_OSC:     rd_byte = {3'h0, fast_startup_enable, trim};
            default:          rd_byte = 8'h00;
        endcase
    end
    // Answer is registered in setup so access always ends in one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_commit_copy: assert property (commit |=>
        chan_word == $past(ieee_word) || $past(scheme_d) != 2'h0 || !$past(scheme_ok))
        else $error("commit did not load ieee word");
    a_ieee_word: assert property (commit && scheme_d == 2'h0 |=>
        chan_word == {8'h00, $past(base_hi_q), $past(base_lo_q)} + {7'h00, $past(prod)}
        + (IS_SUBGHZ ? 24'h000000 : `CPO_OFFSET_2G4))
        else $error("ieee channel word wrong");
    a_fine_lo: assert property (commit && scheme_d == 2'h1 |=>
        chan_word == (IS_SUBGHZ ? $past(fine_word) : $past(chan_word)))
        else $error("fine low word wrong");
    a_fine_mid: assert property (commit && scheme_d == 2'h2 |=>
        chan_word == (IS_SUBGHZ ? $past(fine_word) : $past(chan_word)))
        else $error("fine mid word wrong");
    a_fine_hi: assert property (commit && scheme_d == 2'h3 |=>
        chan_word == (IS_SUBGHZ ? $past(chan_word) : $past(fine_word)))
        else $error("fine high word wrong");
    a_cn_msb: assert property (commit |=> cn_msb_q == $past(pwdata[`CPO_CN_MSB_BIT]))
        else $error("channel msb not stored");
    a_bw_path: assert property (wr_en && idx == `CPO_IDX_SYNTH |=> ##1
        loop_bw_adjust == (IS_SUBGHZ ? $past(pwdata[5:4], 2) : 2'h0))
        else $error("loop bandwidth not applied");
    a_lock_read: assert property (pready && !pwrite && idx == `CPO_IDX_SYNTH |->
        prdata[1] == $past(lock_s) && prdata[7:6] == 2'h0)
        else $error("lock flag readback wrong");
    a_cal_start: assert property ($rose(transmit_prepare_state_s) |=> cal_start ##1
        (!cal_start || $past(commit)))
        else $error("calibration not started");
    a_center: assert property (done_s && !prev_q[2] |=>
        center_q == $past(value_s))
        else $error("center value not captured");
    a_osc_write: assert property (wr_en && idx == `CPO_IDX_OSC |=>
        fast_startup_enable == $past(pwdata[4]) && trim == $past(pwdata[3:0]))
        else $error("oscillator write lost");
    a_lock_events: assert property ($fell(lock_s) |=>
        transceiver_error_irq && !transceiver_ready_irq ##1 !transceiver_error_irq)
        else $error("lock loss event wrong");
    a_reserved: assert property (pready && !pwrite && idx == `CPO_IDX_COMMIT |->
        prdata[5:1] == 5'h00 && prdata[31:8] == 24'h000000)
        else $error("reserved bits not zero");
    c_commit: cover property (commit ##1 cal_start);
    c_lock_cycle: cover property (transceiver_error_irq ##[1:20] transceiver_ready_irq);
    c_unmapped: cover property (pready && pslverr);
endmodule

// *** verif/cpo_regs_tb_top.sv ***
`timescale 1ns/1ns
`include "cpo_defs.svh"
module cpo_regs_tb_top;
    typedef struct packed
    {
        logic       wr;
        logic [9:0] idx;
        logic [7:0] wdat;
        logic [7:0] exp;
    } cpo_row_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'hf;
    logic        lock_pin = 1'b0;
    logic        transmit_prepare_state_pin = 1'b0;
    logic        cal_done_pin = 1'b0;
    logic [5:0]  cal_value_pin = 6'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [23:0] chan_word;
    logic [23:0] chan_word_2g4;
    logic [1:0]  scheme_select;
    logic [1:0]  loop_bw_adjust;
    logic [1:0]  loop_bw_2g4;
    logic        cal_start;
    logic        fast_startup_enable;
    logic [3:0]  trim;
    logic        transceiver_error_irq;
    logic        transceiver_ready_irq;
    int          n_errors = 0;
    int          checked = 0;
    logic [7:0]  rd;
    logic        err;
    int          hits;
    cpo_row_t    rows[8];
    logic [31:0] cm[5][5];

    always #25 pclk = ~pclk;

    cpo_regs #(.IS_SUBGHZ(1'b1)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lock_pin(lock_pin), .transmit_prepare_state_pin(transmit_prepare_state_pin),
        .cal_done_pin(cal_done_pin), .cal_value_pin(cal_value_pin), .chan_word(chan_word),
        .scheme_select(scheme_select), .loop_bw_adjust(loop_bw_adjust), .cal_start(cal_start),
        .fast_startup_enable(fast_startup_enable), .trim(trim),
        .transceiver_error_irq(transceiver_error_irq),
        .transceiver_ready_irq(transceiver_ready_irq));

    // Second radio flavour shares the bus to compare offset and bandwidth handling
    cpo_regs #(.IS_SUBGHZ(1'b0)) i_dut_2g4 (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(), .pready(), .pslverr(),
        .lock_pin(lock_pin), .transmit_prepare_state_pin(transmit_prepare_state_pin), .cal_done_pin(cal_done_pin),
        .cal_value_pin(cal_value_pin), .chan_word(chan_word_2g4), .scheme_select(),
        .loop_bw_adjust(loop_bw_2g4), .cal_start(), .fast_startup_enable(), .trim(),
        .transceiver_error_irq(), .transceiver_ready_irq());

    task automatic end_of_test;
        $display("errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    // Idle cycle first, so psel is never assigned twice in one time step
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                       input logic [3:0] strb);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        pstrb  <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts cycles a pulse is high within an eight-cycle window
    task automatic pulses(input int sel);
        hits = 0;
        repeat (8)
        begin
            @(negedge pclk);
            if ((sel == 0 && transceiver_ready_irq === 1'b1) ||
                (sel == 1 && transceiver_error_irq === 1'b1) || (sel == 2 && cal_start === 1'b1))
                hits++;
        end
    endtask

    initial
    begin
        rows = '{{1'b1, `CPO_IDX_SPACING, 8'h30, 8'h30}, {1'b1, `CPO_IDX_BASE_LO, 8'hf1, 8'hf1},
                 {1'b1, `CPO_IDX_BASE_HI, 8'h86, 8'h86}, {1'b1, `CPO_IDX_CHAN_LO, 8'h02, 8'h02},
                 {1'b1, `CPO_IDX_OSC, 8'hff, 8'h1f}, {1'b1, `CPO_IDX_OSC, 8'h05, 8'h05},
                 {1'b1, `CPO_IDX_SYNTH, 8'h6f, 8'h20}, {1'b1, `CPO_IDX_CENTER, 8'hff, 8'h00}};
        // Commit value, sub-GHz word, 2.4 GHz word, scheme, start pulse
        cm = '{'{32'h00, 32'h008751, 32'h0171b1, 32'h0, 32'h1},
               '{32'h01, 32'h00b751, 32'h01a1b1, 32'h0, 32'h1},
               '{32'h40, 32'h86f102, 32'h01a1b1, 32'h1, 32'h1},
               '{32'h80, 32'h86f102, 32'h01a1b1, 32'h2, 32'h1},
               '{32'hc0, 32'h86f102, 32'h86f102, 32'h3, 32'h0}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        chk("chan_word reset", 32'h008cf8, {8'h0, chan_word});
        chk("fast reset", 32'h1, {31'h0, fast_startup_enable});
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].idx, rows[i].wdat, 4'hf);
            apb(1'b0, rows[i].idx, 8'h00, 4'hf);
            chk("row readback", {24'h0, rows[i].exp}, {24'h0, rd});
            chk("row err", 32'h0, {31'h0, err});
        end
        chk("word before commit", 32'h008cf8, {8'h0, chan_word});
        chk("word 2g4 before commit", 32'h017758, {8'h0, chan_word_2g4});
        chk("loop bw", 32'h2, {30'h0, loop_bw_adjust});
        chk("loop bw 2g4", 32'h0, {30'h0, loop_bw_2g4});
        chk("trim", 32'h5, {28'h0, trim});
        chk("fast", 32'h0, {31'h0, fast_startup_enable});
        foreach (cm[i])
        begin
            apb(1'b1, `CPO_IDX_COMMIT, cm[i][0][7:0], 4'hf);
            #1;
            chk("cal_start on commit", cm[i][4], {31'h0, cal_start});
            chk("chan_word", cm[i][1], {8'h0, chan_word});
            chk("chan_word 2g4", cm[i][2], {8'h0, chan_word_2g4});
            chk("scheme", cm[i][3], {30'h0, scheme_select});
            apb(1'b0, `CPO_IDX_COMMIT, 8'h00, 4'hf);
            chk("commit readback", cm[i][0], {24'h0, rd});
        end
        apb(1'b1, `CPO_IDX_SPACING, 8'h55, 4'he);
        apb(1'b0, `CPO_IDX_SPACING, 8'h00, 4'hf);
        chk("strobe-less write", 32'h30, {24'h0, rd});
        apb(1'b1, 10'h007, 8'h55, 4'hf);
        chk("unmapped write err", 32'h1, {31'h0, err});
        apb(1'b0, 10'h007, 8'h00, 4'hf);
        chk("unmapped read", 32'h100, {23'h0, err, rd});
        lock_pin <= 1'b1;
        pulses(0);
        chk("ready pulse", 32'h1, hits);
        apb(1'b0, `CPO_IDX_SYNTH, 8'h00, 4'hf);
        chk("lock flag set", 32'h22, {24'h0, rd});
        lock_pin <= 1'b0;
        pulses(1);
        chk("error pulse", 32'h1, hits);
        apb(1'b0, `CPO_IDX_SYNTH, 8'h00, 4'hf);
        chk("lock flag clear", 32'h20, {24'h0, rd});
        transmit_prepare_state_pin <= 1'b1;
        pulses(2);
        chk("cal_start on prepare", 32'h1, hits);
        cal_value_pin <= 6'h2a;
        repeat (4) @(posedge pclk);
        cal_done_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, `CPO_IDX_CENTER, 8'h00, 4'hf);
        chk("center value", 32'h2a, {24'h0, rd});
        @(posedge pclk);
        transmit_prepare_state_pin   <= 1'b0;
        cal_done_pin <= 1'b0;
        presetn      <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("chan_word re-reset", 32'h008cf8, {8'h0, chan_word});
        chk("chan_word 2g4 re-reset", 32'h017758, {8'h0, chan_word_2g4});
        rows = '{{1'b0, `CPO_IDX_SPACING, 8'h0, 8'h08}, {1'b0, `CPO_IDX_BASE_LO, 8'h0, 8'hf8},
                 {1'b0, `CPO_IDX_BASE_HI, 8'h0, 8'h8c}, {1'b0, `CPO_IDX_CHAN_LO, 8'h0, 8'h00},
                 {1'b0, `CPO_IDX_COMMIT, 8'h0, 8'h00}, {1'b0, `CPO_IDX_SYNTH, 8'h0, 8'h00},
                 {1'b0, `CPO_IDX_CENTER, 8'h0, 8'h00}, {1'b0, `CPO_IDX_OSC, 8'h0, 8'h10}};
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].idx, 8'h00, 4'hf);
            chk("reset readback", {24'h0, rows[i].exp}, {24'h0, rd});
        end
        end_of_test();
    end

    // Whole run is under two hundred cycles; this margin only catches a hang
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        end_of_test();
    end
endmodule
